/* File: rtl/mcsps_pkg.sv */
/*
 * Package for the main clock select, prescale and sleep block.
 * Assumes an APB slave with 32-bit data, one register to a word.
 */
package mcsps_pkg;
	// Byte addresses of the registers
	localparam logic [7:0] ADDR_PRESCALE = 8'h36; // Printed offset is not a multiple of four: index
	localparam logic [9:0] BADDR_PRESCALE = 10'h0D8; // Index 0x36 times four
	localparam logic [9:0] BADDR_SELECT = 10'h0E0;
	localparam logic [9:0] BADDR_TRIM = 10'h0E4;
	localparam logic [9:0] BADDR_PROTECT = 10'h0E8;
	localparam logic [9:0] BADDR_SLEEP = 10'h0EC;
	localparam logic [9:0] BADDR_STATUS = 10'h0F0;
	// Reset values and codes
	localparam logic [3:0] DIV_RESET = 4'h3;
	localparam logic [3:0] DIV_MAX = 4'h8;
	localparam logic [1:0] SRC_RESET = 2'h0;
	localparam logic [7:0] PROTECT_SIG = 8'hD8;
	localparam logic [2:0] WINDOW_CYCLES = 3'h4;
	localparam logic [2:0] WAKE_HOLD = 3'h4;
	localparam logic [2:0] OSC_START = 3'h6;
	localparam logic [2:0] MODE_IDLE = 3'h0;
	localparam logic [2:0] MODE_NOISE = 3'h1;
	localparam logic [2:0] MODE_PDOWN = 3'h2;
	localparam logic [2:0] MODE_STBY = 3'h4;
	// Gated clock domain enables
	typedef struct packed {
		logic cpu;
		logic mem;
		logic io;
		logic conv;
		logic main_osc;
	} mcsps_dom_t;
	// Wake sources
	typedef struct packed {
		logic ext_level;
		logic ext_edge;
		logic pin_change;
		logic converter;
		logic watchdog;
		logic monitor;
		logic other_io;
	} mcsps_wake_t;
endpackage : mcsps_pkg

/* File: rtl/mcsps_top.sv */
/*
 * Main clock select, trim, power-of-two prescaler and sleep control.
 * Assumes three free-running source clocks arrive as levels sampled on pclk,
 * a CPU issuing a one-cycle sleep pulse, and instruction cycles counted on pclk.
 */
`timescale 1ns/1ps
// Functional notes
// R1: Source code 00 internal oscillator, 01 watchdog oscillator, 10 external clock.
// R2: Source select writable at run time; switching is glitch free.
// R3: Source write accepted only within four cycles of the unlock signature.
// R4: Divider write accepted only within four cycles of the unlock signature.
// R5: Upper six bits of source select read zero.
// R6: Reset loads the factory calibration value into the trim register.
// R7: Trim register writable; higher value means higher frequency.
// R8: Divider divides main clock by two to the field, codes up to 8.
// R9: Divided clock drives CPU and all synchronous peripherals together.
// R10: Divider resets to 0011, divide by eight.
// R11: Upper four prescale bits read zero.
// R12: Software keeps interrupts off during protected divider change.
// R13: Software picks a divider keeping system clock within limits.
// R14: Sleep only when enable bit set and sleep instruction executes.
// R15: Each sleep mode stops its listed clock domains.
// R16: Each sleep mode wakes only on its listed sources.
// R17: In deeper modes external line wakes only when level sensitive.
// R18: On wake, hold CPU four cycles beyond start-up.
// R19: Waking leaves register file and SRAM untouched.
// R20: Reset during sleep wakes and restarts at reset vector.
// R21: Level wake source holds its level long enough.
// R22: Mode codes idle 000, noise 001, power-down 010, standby 100.
// R23: Divider change has no glitch nor faster intermediate frequency.
// R24: Power-down wake counts six oscillator cycles; others add none.
// R25: Window opens on signature, closes after four cycles or first write.
// R26: Reserved source or divider codes keep the previous setting.
module mcsps_top #(
	parameter logic [7:0] FACTORY_TRIM = 8'h80 // Arbitrary calibration default
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic osc_int,
	input wire logic osc_wdt,
	input wire logic clk_ext,
	input wire logic sleep_instr,
	input wire mcsps_pkg::mcsps_wake_t wake_req,
	input wire logic ext_level_mode,
	output logic [7:0] oscillator_trim,
	output logic sys_clk_en,
	output mcsps_pkg::mcsps_dom_t dom_en,
	output logic cpu_hold,
	output logic asleep
);
	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_SLEEP = 4'h2,
		ST_START = 4'h4,
		ST_HOLD = 4'h8
	} mcsps_state_t;

	logic [1:0] main_source_sel;
	logic [3:0] clock_divider_sel;
	logic [2:0] sleep_mode_field;
	logic sleep_enable_bit;
	logic [2:0] win_cnt;
	logic [2:0] seq_cnt;
	logic [8:0] src_sync [3];
	logic [2:0] src_lvl;
	logic [2:0] src_prev;
	logic [1:0] active_src;
	logic [1:0] pend_src;
	logic switching;
	logic main_tick;
	logic [7:0] ripple;
	logic [3:0] active_div;
	logic wake_hit;
	mcsps_state_t state;
	mcsps_state_t next_state;
	logic wr;
	logic rd;
	logic [9:0] ba;
	logic window_open;

	// Bus decode; zero wait states
	assign ba = paddr[9:0];
	assign wr = psel && penable && pwrite && pstrb[0];
	assign rd = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign window_open = (win_cnt != 3'h0);

	function automatic logic mapped(input logic [9:0] a);
		mapped = (a == mcsps_pkg::BADDR_PRESCALE) || (a == mcsps_pkg::BADDR_SELECT) ||
			(a == mcsps_pkg::BADDR_TRIM) || (a == mcsps_pkg::BADDR_PROTECT) ||
			(a == mcsps_pkg::BADDR_SLEEP) || (a == mcsps_pkg::BADDR_STATUS);
	endfunction : mapped

	assign pslverr = psel && penable && !mapped(ba);

	// Change-enable window counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_cnt <= 3'h0;
		end else if (wr && ba == mcsps_pkg::BADDR_PROTECT && pwdata[7:0] == mcsps_pkg::PROTECT_SIG) begin
			win_cnt <= mcsps_pkg::WINDOW_CYCLES; // R25
		end else if (wr && window_open && (ba == mcsps_pkg::BADDR_SELECT || ba == mcsps_pkg::BADDR_PRESCALE)) begin
			win_cnt <= 3'h0; // R25
		end else if (window_open) begin
			win_cnt <= win_cnt - 3'h1; // R25
		end
	end

	// Protected source select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			main_source_sel <= mcsps_pkg::SRC_RESET;
		end else if (wr && ba == mcsps_pkg::BADDR_SELECT && window_open && pwdata[1:0] != 2'h3) begin
			main_source_sel <= pwdata[1:0]; // R3 R26
		end
	end

	// Protected divider select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_divider_sel <= mcsps_pkg::DIV_RESET; // R10
		end else if (wr && ba == mcsps_pkg::BADDR_PRESCALE && window_open && pwdata[3:0] <= mcsps_pkg::DIV_MAX) begin
			clock_divider_sel <= pwdata[3:0]; // R4 R26
		end
	end

	// Trim and sleep control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oscillator_trim <= FACTORY_TRIM; // R6
			sleep_mode_field <= mcsps_pkg::MODE_IDLE;
			sleep_enable_bit <= 1'b0;
		end else if (wr && ba == mcsps_pkg::BADDR_TRIM) begin
			oscillator_trim <= pwdata[7:0]; // R7
		end else if (wr && ba == mcsps_pkg::BADDR_SLEEP) begin
			sleep_mode_field <= pwdata[3:1];
			sleep_enable_bit <= pwdata[0];
		end
	end

	// Source clock synchronisers; second and third stage must agree
	for (genvar i = 0; i < 3; i++) begin : g_sync
		logic raw;
		assign raw = (i == 0) ? osc_int : (i == 1) ? osc_wdt : clk_ext;
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				src_sync[i] <= 9'h000;
				src_lvl[i] <= 1'b0;
			end else begin
				src_sync[i] <= {src_sync[i][7:0], raw};
				if (src_sync[i][1] == src_sync[i][2]) begin
					src_lvl[i] <= src_sync[i][2];
				end
			end
		end
	end

	// Rising edges of each filtered source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_prev <= 3'h0;
		end else begin
			src_prev <= src_lvl;
		end
	end

	// Glitch-free switch: change only at a low phase of both old and new
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_src <= mcsps_pkg::SRC_RESET;
			pend_src <= mcsps_pkg::SRC_RESET;
			switching <= 1'b0;
		end else if (!switching && main_source_sel != active_src) begin
			pend_src <= main_source_sel; // R2
			switching <= 1'b1;
		end else if (switching && !src_lvl[active_src] && !src_lvl[pend_src]) begin
			active_src <= pend_src; // R1 R2
			switching <= 1'b0;
		end
	end

	assign main_tick = !switching && src_lvl[active_src] && !src_prev[active_src] &&
		dom_en.main_osc; // R1 R15

	// Prescaler: divider updates only at a whole-period boundary of both settings
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ripple <= 8'h00;
			active_div <= mcsps_pkg::DIV_RESET;
		end else if (main_tick) begin
			ripple <= ripple + 8'h01;
			if (((ripple + 8'h01) & ((8'h01 << active_div) - 8'h01)) == 8'h00 &&
				((ripple + 8'h01) & ((8'h01 << clock_divider_sel) - 8'h01)) == 8'h00) begin
				active_div <= clock_divider_sel; // R23
			end
		end
	end

	// System clock enable pulse drives every synchronous domain
	assign sys_clk_en = main_tick && ((ripple & ((8'h01 << active_div) - 8'h01)) == 8'h00); // R8 R9

	// Wake qualification per mode
	always_comb begin
		wake_hit = 1'b0;
		case (sleep_mode_field)
			mcsps_pkg::MODE_IDLE: wake_hit = |wake_req; // R16
			mcsps_pkg::MODE_NOISE: wake_hit = (wake_req.ext_level && ext_level_mode) || wake_req.pin_change ||
				wake_req.converter || wake_req.watchdog || wake_req.monitor; // R16 R17
			default: wake_hit = (wake_req.ext_level && ext_level_mode) || wake_req.pin_change ||
				wake_req.watchdog; // R16 R17
		endcase
	end

	// Sleep state machine
	always_comb begin
		next_state = state;
		case (state)
			ST_RUN: if (sleep_instr && sleep_enable_bit) next_state = ST_SLEEP; // R14
			ST_SLEEP: if (wake_hit) next_state = (sleep_mode_field == mcsps_pkg::MODE_PDOWN) ? ST_START : ST_HOLD;
			ST_START: if (seq_cnt == 3'h0) next_state = ST_HOLD; // R24
			ST_HOLD: if (seq_cnt == 3'h0) next_state = ST_RUN; // R18
			default: next_state = ST_RUN;
		endcase
	end

	// State register; reset here returns to run (R20)
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_RUN; // R20
		end else begin
			state <= next_state;
		end
	end

	// Start-up and hold counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_cnt <= 3'h7;
		end else if (state == ST_SLEEP && next_state == ST_START) begin
			seq_cnt <= mcsps_pkg::OSC_START; // R24
		end else if (next_state == ST_HOLD && state != ST_HOLD) begin
			seq_cnt <= mcsps_pkg::WAKE_HOLD - 3'h1;
		end else if (state == ST_START && main_tick_raw()) begin
			seq_cnt <= seq_cnt - 3'h1; // R24
		end else if (state == ST_HOLD && seq_cnt != 3'h0) begin
			seq_cnt <= seq_cnt - 3'h1; // R18
		end else if (state == ST_RUN && seq_cnt == 3'h7 && oscillator_trim != 8'h00) begin
			seq_cnt <= 3'h0;
		end
	end

	function automatic logic main_tick_raw();
		main_tick_raw = src_lvl[active_src] && !src_prev[active_src];
	endfunction : main_tick_raw

	// Domain gating per mode; register file and SRAM keep contents (R19)
	always_comb begin
		dom_en = '{cpu: 1'b1, mem: 1'b1, io: 1'b1, conv: 1'b1, main_osc: 1'b1};
		if (state == ST_SLEEP) begin
			dom_en.cpu = 1'b0; // R15
			dom_en.mem = 1'b0;
			dom_en.io = (sleep_mode_field == mcsps_pkg::MODE_IDLE); // R15 R22
			dom_en.conv = (sleep_mode_field == mcsps_pkg::MODE_IDLE) ||
				(sleep_mode_field == mcsps_pkg::MODE_NOISE);
			dom_en.main_osc = (sleep_mode_field != mcsps_pkg::MODE_PDOWN); // R15
		end else if (state != ST_RUN) begin
			dom_en.cpu = 1'b0;
			dom_en.mem = 1'b0;
		end
	end

	assign cpu_hold = (state != ST_RUN);
	assign asleep = (state == ST_SLEEP);

	// Read data; reserved bits zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (ba)
				mcsps_pkg::BADDR_PRESCALE: prdata <= {28'h0000000, clock_divider_sel}; // R11
				mcsps_pkg::BADDR_SELECT: prdata <= {30'h00000000, main_source_sel}; // R5
				mcsps_pkg::BADDR_TRIM: prdata <= {24'h000000, oscillator_trim};
				mcsps_pkg::BADDR_SLEEP: prdata <= {28'h0000000, sleep_mode_field, sleep_enable_bit};
				mcsps_pkg::BADDR_STATUS: prdata <= {25'h0000000, switching, active_src, active_div};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Checks
	a_window_gate: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && ba == mcsps_pkg::BADDR_SELECT && !window_open) |=> $stable(main_source_sel)) // R3
		else $error("source changed outside window");
	a_div_gate: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && ba == mcsps_pkg::BADDR_PRESCALE && !window_open) |=> $stable(clock_divider_sel)) // R4
		else $error("divider changed outside window");
	a_window_len: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(window_open) && !wr |-> ##4 !window_open) // R25
		else $error("window not four cycles");
	a_div_legal: assert property (@(posedge pclk) disable iff (!presetn)
		clock_divider_sel <= mcsps_pkg::DIV_MAX) // R26
		else $error("reserved divider held");
	a_sleep_entry: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ST_RUN && sleep_instr && !sleep_enable_bit) |=> state == ST_RUN) // R14
		else $error("sleep without enable");
	a_pdown_osc: assert property (@(posedge pclk) disable iff (!presetn)
		(asleep && sleep_mode_field == mcsps_pkg::MODE_PDOWN) |-> !dom_en.main_osc && !dom_en.io) // R15
		else $error("power-down clocks running");
	a_hold_four: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(state == ST_HOLD) |-> (state == ST_HOLD)[*4] ##1 state == ST_RUN) // R18
		else $error("hold not four cycles");
	a_idle_fast: assert property (@(posedge pclk) disable iff (!presetn)
		(asleep && sleep_mode_field == mcsps_pkg::MODE_IDLE && wake_hit) |=> state == ST_HOLD) // R24
		else $error("idle wake delayed");
	// Domain gating per sleep mode
	a_idle_dom: assert property (@(posedge pclk) disable iff (!presetn)
		(asleep && sleep_mode_field == mcsps_pkg::MODE_IDLE) |-> dom_en.io && dom_en.conv && dom_en.main_osc) // R15
		else $error("idle clocks stopped");
	a_noise_dom: assert property (@(posedge pclk) disable iff (!presetn)
		(asleep && sleep_mode_field == mcsps_pkg::MODE_NOISE) |-> !dom_en.io && dom_en.conv && dom_en.main_osc) // R15
		else $error("noise mode clocks wrong");
	a_stby_dom: assert property (@(posedge pclk) disable iff (!presetn)
		(asleep && sleep_mode_field == mcsps_pkg::MODE_STBY) |-> !dom_en.io && !dom_en.conv && dom_en.main_osc) // R15
		else $error("standby clocks wrong");
	a_sleep_cpu: assert property (@(posedge pclk) disable iff (!presetn)
		asleep |-> !dom_en.cpu && !dom_en.mem) // R15
		else $error("cpu clock runs in sleep");
	a_tick_gated: assert property (@(posedge pclk) disable iff (!presetn)
		!dom_en.main_osc |-> !sys_clk_en) // R15
		else $error("system clock with source off");
	// Reserved codes and window opening
	a_div_reject: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && ba == mcsps_pkg::BADDR_PRESCALE && pwdata[3:0] > mcsps_pkg::DIV_MAX) |=> $stable(clock_divider_sel)) // R26
		else $error("reserved divider taken");
	a_src_reject: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && ba == mcsps_pkg::BADDR_SELECT && pwdata[1:0] == 2'h3) |=> $stable(main_source_sel)) // R26
		else $error("reserved source taken");
	a_window_open: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && ba == mcsps_pkg::BADDR_PROTECT && pwdata[7:0] == mcsps_pkg::PROTECT_SIG) |=> window_open) // R25
		else $error("signature did not open window");
	a_active_legal: assert property (@(posedge pclk) disable iff (!presetn)
		active_div <= mcsps_pkg::DIV_MAX) // R23
		else $error("prescaler runs reserved setting");
	// Wake sources and start-up
	a_deep_wake: assert property (@(posedge pclk) disable iff (!presetn)
		(asleep && sleep_mode_field != mcsps_pkg::MODE_IDLE && sleep_mode_field != mcsps_pkg::MODE_NOISE &&
		!wake_req.ext_level && !wake_req.pin_change && !wake_req.watchdog) |=> asleep) // R16
		else $error("deep sleep woke on wrong source");
	a_pdown_start: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(state == ST_START) |-> (state == ST_START)[*6]) // R24
		else $error("oscillator start too short");
	a_hold_cpu: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ST_HOLD) |-> cpu_hold && !dom_en.cpu) // R18
		else $error("cpu runs during hold");
	// Main scenarios
	c_pdown_wake: cover property (@(posedge pclk) state == ST_START ##[1:200] state == ST_RUN);
	c_sleep_entry: cover property (@(posedge pclk) $rose(asleep));
	c_window: cover property (@(posedge pclk) $rose(window_open));
	c_src_switch: cover property (@(posedge pclk) $fell(switching));
	c_div_change: cover property (@(posedge pclk) $changed(active_div));
endmodule : mcsps_top

/* File: verification/mcsps_core_model.sv */
/* CPU core stand-in: source oscillators and the sleep instruction.
 * Assumes pclk at 100 MHz; oscillators stop while run is low. */
`timescale 1ns/1ps
module mcsps_core_model (
	input wire logic pclk,
	input wire logic run,
	output logic osc_int,
	output logic osc_wdt,
	output logic clk_ext,
	output logic sleep_instr
);
	logic [3:0] div_cnt = 4'h0;
	// Quiet start
	initial begin
		osc_int = 1'b0;
		osc_wdt = 1'b0;
		clk_ext = 1'b0;
		sleep_instr = 1'b0;
	end
	// Source clocks, halted while the main source is disabled
	always @(posedge pclk) begin
		if (run) begin
			div_cnt <= div_cnt + 4'h1;
			osc_int <= div_cnt[1];
			osc_wdt <= div_cnt[3];
			clk_ext <= div_cnt[2];
		end
	end
	// One-cycle sleep instruction
	task do_sleep();
		@(posedge pclk);
		sleep_instr <= 1'b1;
		@(posedge pclk);
		sleep_instr <= 1'b0;
	endtask : do_sleep
endmodule : mcsps_core_model

/* File: verification/tb_main_clock_select_prescale_sleep.sv */
/* Bench for the clock select, prescale and sleep block over APB.
 * Assumes zero-wait APB slave and the core model driving sources. */
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
	$display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_main_clock_select_prescale_sleep;
	logic pclk, presetn, psel, penable, pwrite, err, sleep_instr, osc_int, osc_wdt, clk_ext;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic pready, pslverr, ext_level_mode, sys_clk_en, cpu_hold, asleep;
	logic [7:0] oscillator_trim;
	mcsps_pkg::mcsps_wake_t wake_req;
	mcsps_pkg::mcsps_dom_t dom_en;
	int bad_count = 0;
	int check_count = 0;
	int cyc = 0;
	int n;
	logic [2:0] mode_x [4] = '{3'h0, 3'h1, 3'h4, 3'h2};
	logic [4:0] dom_x [4] = '{5'h07, 5'h03, 5'h01, 5'h00};
	logic [6:0] no_x [4] = '{7'h00, 7'h01, 7'h08, 7'h20};
	logic [6:0] yes_x [4] = '{7'h01, 7'h08, 7'h04, 7'h40};
	mcsps_top #(.FACTORY_TRIM(8'h5A)) mcsps_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_int(osc_int), .osc_wdt(osc_wdt),
		.clk_ext(clk_ext), .sleep_instr(sleep_instr), .wake_req(wake_req),
		.ext_level_mode(ext_level_mode), .oscillator_trim(oscillator_trim), .sys_clk_en(sys_clk_en),
		.dom_en(dom_en), .cpu_hold(cpu_hold), .asleep(asleep));
	mcsps_core_model mcsps_core_model_i (.pclk(pclk), .run(dom_en.main_osc), .osc_int(osc_int),
		.osc_wdt(osc_wdt), .clk_ext(clk_ext), .sleep_instr(sleep_instr));
	// Clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			stop_test();
		end
	end
	// Verdict
	task stop_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {22'h0, a};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && k < 50) begin
			k++;
			@(posedge pclk);
		end
		if (k >= 50) bad_count++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd_chk(input logic [9:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask : rd_chk
	// Unlock then protected write
	task pwr(input logic [9:0] a, input logic [31:0] d);
		apb(1'b1, mcsps_pkg::BADDR_PROTECT, {24'h0, mcsps_pkg::PROTECT_SIG});
		apb(1'b1, a, d);
	endtask : pwr
	// Wait for a source or divider switch to settle
	task poll_status(input logic [6:0] e);
		n = 0;
		rd = 32'h40;
		while (rd[6:0] !== e && n < 2000) begin
			n++;
			apb(1'b0, mcsps_pkg::BADDR_STATUS, 32'h0);
		end
		`CHK(rd[6:0], e)
	endtask : poll_status
	initial begin
		{psel, penable, pwrite, paddr, pwdata, ext_level_mode} = '0;
		pstrb = 4'hF;
		wake_req = '0;
		presetn = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (20) @(posedge pclk);
		rd_chk(mcsps_pkg::BADDR_PRESCALE, 32'h3);
		rd_chk(mcsps_pkg::BADDR_SELECT, 32'h0);
		rd_chk(mcsps_pkg::BADDR_TRIM, 32'h5A);
		`CHK(oscillator_trim, 8'h5A)
		$display("reset test done");
		apb(1'b1, mcsps_pkg::BADDR_PRESCALE, 32'h0);
		rd_chk(mcsps_pkg::BADDR_PRESCALE, 32'h3);
		pwr(mcsps_pkg::BADDR_PRESCALE, 32'hF5);
		rd_chk(mcsps_pkg::BADDR_PRESCALE, 32'h5);
		pwr(mcsps_pkg::BADDR_PRESCALE, 32'h9);
		rd_chk(mcsps_pkg::BADDR_PRESCALE, 32'h5);
		pwr(mcsps_pkg::BADDR_PRESCALE, 32'h8);
		poll_status(7'h08);
		`CHK(rd[3:0], 4'h8)
		apb(1'b1, mcsps_pkg::BADDR_PROTECT, 32'hD8);
		repeat (8) @(posedge pclk);
		apb(1'b1, mcsps_pkg::BADDR_PRESCALE, 32'h0);
		rd_chk(mcsps_pkg::BADDR_PRESCALE, 32'h8);
		pwr(mcsps_pkg::BADDR_PRESCALE, 32'h2);
		apb(1'b1, mcsps_pkg::BADDR_PRESCALE, 32'h1);
		rd_chk(mcsps_pkg::BADDR_PRESCALE, 32'h2);
		poll_status(7'h02);
		$display("prescale test done");
		for (int s = 1; s < 4; s++) begin
			pwr(mcsps_pkg::BADDR_SELECT, 32'hFC | (s % 3));
			rd_chk(mcsps_pkg::BADDR_SELECT, s % 3);
			poll_status({1'b0, 2'(s % 3), 4'h2});
			`CHK(rd[5:4], 2'(s % 3))
		end
		pwr(mcsps_pkg::BADDR_SELECT, 32'h3);
		apb(1'b1, mcsps_pkg::BADDR_SELECT, 32'h2);
		rd_chk(mcsps_pkg::BADDR_SELECT, 32'h0);
		$display("select test done");
		for (int v = 0; v < 2; v++) begin
			apb(1'b1, mcsps_pkg::BADDR_TRIM, v ? 32'hFF : 32'h0);
			rd_chk(mcsps_pkg::BADDR_TRIM, v ? 32'hFF : 32'h0);
			`CHK(oscillator_trim, v ? 8'hFF : 8'h00)
		end
		apb(1'b0, 10'h3F0, 32'h0);
		`CHK(err, 1'b1)
		$display("trim and map test done");
		ext_level_mode <= 1'b1;
		apb(1'b1, mcsps_pkg::BADDR_SLEEP, 32'h0);
		mcsps_core_model_i.do_sleep();
		repeat (4) @(posedge pclk);
		`CHK(asleep, 1'b0)
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, mcsps_pkg::BADDR_SLEEP, {28'h0, mode_x[m], 1'b1});
			mcsps_core_model_i.do_sleep();
			repeat (4) @(posedge pclk);
			`CHK(asleep, 1'b1)
			`CHK(dom_en, dom_x[m])
			wake_req <= no_x[m];
			repeat (30) @(posedge pclk);
			`CHK(asleep, 1'b1)
			wake_req <= yes_x[m];
			n = 0;
			while (asleep !== 1'b0 && n < 300) begin
				n++;
				@(posedge pclk);
			end
			`CHK(n < 300, 1'b1)
			wake_req <= '0;
			n = 0;
			while (cpu_hold === 1'b1 && n < 100) begin
				n++;
				@(posedge pclk);
			end
			`CHK(n >= 4, 1'b1)
			`CHK(n < 100, 1'b1)
			`CHK(dom_en, 5'h1F)
		end
		mcsps_core_model_i.do_sleep();
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		`CHK(asleep, 1'b0)
		rd_chk(mcsps_pkg::BADDR_PRESCALE, 32'h3);
		$display("sleep test done");
		stop_test();
	end
endmodule : tb_main_clock_select_prescale_sleep
